// ===== pkg/mpl_pcs_pkg.sv
// constants, code groups and register layout of the 4B/5B coding sublayer
package mpl_pcs_pkg;

  // ***************************************************
  // clocking
  // ***************************************************
  localparam int CORE_HZ = 100_000_000;
  localparam int MII_HZ_FAST = 25_000_000;
  localparam int MII_HZ_SLOW = 2_500_000;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_HALF_FAST =
    DIV_W'(CORE_HZ / (2 * MII_HZ_FAST));
  localparam logic [DIV_W-1:0] DIV_HALF_SLOW =
    DIV_W'(CORE_HZ / (2 * MII_HZ_SLOW));

  // ***************************************************
  // code groups
  // ***************************************************
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD = 4'h5;
  localparam logic [4:0] ENC_TABLE [16] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  // ***************************************************
  // registers
  // ***************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ERRCNT = 8'h08;
  localparam int CTRL_W = 6;
  localparam int CTL_SPEED100 = 0;
  localparam int CTL_FULLDUP = 1;
  localparam int CTL_AUTONEG = 2;
  localparam int CTL_TESTLOOP = 3;
  localparam int CTL_LBDIS = 4;
  localparam int CTL_FIBER = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h01;
  localparam int ST_CRS = 0;
  localparam int ST_COL = 1;
  localparam int ST_TXACT = 2;
  localparam int ST_RXACT = 3;
  localparam int ST_TESTLB = 4;
  localparam int ST_OPLB = 5;
  localparam int ST_FIBER = 6;
  localparam int ERRCNT_W = 16;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_K = 4'h2,
    TX_DATA = 4'h4,
    TX_R = 4'h8
  } mpl_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_GOTJ = 4'h2,
    RX_FRAME = 4'h4,
    RX_GOTT = 4'h8
  } mpl_rx_state_t;

endpackage : mpl_pcs_pkg

// ===== hdl/mpl_pcs.sv
// 4B/5B coding sublayer with MII, loopbacks, carrier and collision
`timescale 1ns/10ps
module mpl_pcs
  import mpl_pcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic txClk,
  output logic rxClk,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [3:0] txd,
  output logic rxDv,
  output logic rxEr,
  output logic [3:0] rxd,
  output logic crs,
  output logic col,
  input wire logic lineRxClk,
  input wire logic [4:0] lineRxGroup,
  input wire logic fiberSignalDetect,
  output logic [4:0] lineTransmitPair,
  output logic lineTransmitOff
);

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [4:0] decode(input logic [4:0] g);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (ENC_TABLE[i] == g)
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : decode

  // running line level: a one bit toggles the line
  function automatic logic [5:0] nrziEnc(input logic [4:0] g,
                                         input logic lvl);
    logic l;
    logic [4:0] o;
    l = lvl;
    o = 5'h00;
    for (int i = 4; i >= 0; i--)
    begin
      l = l ^ g[i];
      o[i] = l;
    end
    return {l, o};
  endfunction : nrziEnc

  function automatic logic [5:0] nrziDec(input logic [4:0] g,
                                         input logic lvl);
    logic l;
    logic [4:0] o;
    l = lvl;
    o = 5'h00;
    for (int i = 4; i >= 0; i--)
    begin
      o[i] = l ^ g[i];
      l = g[i];
    end
    return {l, o};
  endfunction : nrziDec

  // ***************************************************
  // input synchronisers
  // ***************************************************
  logic [1:0] txEnS_r, txErS_r, sdS_r, lrcS_r;
  logic [3:0] txd1_r, txd2_r;
  logic [4:0] lrg1_r, lrg2_r;
  logic lrcPrev_r;
  logic lineEvent;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      txEnS_r <= 2'h0;
      txErS_r <= 2'h0;
      sdS_r <= 2'h0;
      lrcS_r <= 2'h0;
      txd1_r <= 4'h0;
      txd2_r <= 4'h0;
      lrg1_r <= 5'h00;
      lrg2_r <= 5'h00;
      lrcPrev_r <= 1'b0;
    end
    else
    begin
      txEnS_r <= {txEnS_r[0], txEn};
      txErS_r <= {txErS_r[0], txEr};
      sdS_r <= {sdS_r[0], fiberSignalDetect};
      lrcS_r <= {lrcS_r[0], lineRxClk};
      txd1_r <= txd;
      txd2_r <= txd1_r;
      lrg1_r <= lineRxGroup;
      lrg2_r <= lrg1_r;
      lrcPrev_r <= lrcS_r[1];
    end
  end

  assign lineEvent = lrcS_r[1] & ~lrcPrev_r;

  // ***************************************************
  // control decode
  // ***************************************************
  logic [CTRL_W-1:0] ctrl_r;
  logic speed100, fullDup, autoNeg, fiberActive, testLoop, opLoopOk;
  logic loopSel, txActive, rxActive;
  logic opTail_r;

  assign speed100 = ctrl_r[CTL_SPEED100];
  assign fullDup = ctrl_r[CTL_FULLDUP];
  assign autoNeg = ctrl_r[CTL_AUTONEG];
  assign fiberActive = ctrl_r[CTL_FIBER] & ~autoNeg & speed100;
  assign testLoop = ctrl_r[CTL_TESTLOOP] &
    (fiberActive ? sdS_r[1] : (fullDup & ~autoNeg));
  assign opLoopOk = ~speed100 & ~fullDup & ~ctrl_r[CTL_LBDIS];
  assign loopSel = testLoop | (opLoopOk & (txEnS_r[1] | opTail_r));

  // ***************************************************
  // interface clocks
  // ***************************************************
  logic [DIV_W-1:0] divCnt_r, divHalf;
  logic miiClk_r, divWrap, txEvent;

  assign divHalf = speed100 ? DIV_HALF_FAST : DIV_HALF_SLOW;
  assign divWrap = divCnt_r == divHalf - DIV_W'(1);
  // inputs are two core cycles old here, within one period of the interface clock
  assign txEvent = divWrap & ~miiClk_r;

  always_ff @(posedge core_clk)
  begin
    if (rst || divWrap)
    begin
      divCnt_r <= '0;
    end
    else
    begin
      divCnt_r <= divCnt_r + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      miiClk_r <= 1'b0;
    end
    else if (divWrap)
    begin
      miiClk_r <= ~miiClk_r;
    end
  end

  assign txClk = miiClk_r;
  assign rxClk = miiClk_r;

  // ***************************************************
  // transmit encoder
  // ***************************************************
  mpl_tx_state_t txState_r, txStateNxt;
  logic [4:0] txGroupNxt;
  logic [5:0] txNrzi;
  logic txLevel_r;
  logic [4:0] lineTransmitPair_r;
  logic lineTransmitOff_r;

  always_comb
  begin
    txStateNxt = txState_r;
    txGroupNxt = CG_IDLE;
    unique case (txState_r)
      TX_IDLE:
        if (txEnS_r[1])
        begin
          txGroupNxt = CG_J;
          txStateNxt = TX_K;
        end
      TX_K:
        if (txEnS_r[1])
        begin
          txGroupNxt = CG_K;
          txStateNxt = TX_DATA;
        end
        else
        begin
          txGroupNxt = CG_T;
          txStateNxt = TX_R;
        end
      TX_DATA:
        if (txEnS_r[1])
        begin
          txGroupNxt = txErS_r[1] ? CG_H : ENC_TABLE[txd2_r];
        end
        else
        begin
          txGroupNxt = CG_T;
          txStateNxt = TX_R;
        end
      TX_R:
      begin
        txGroupNxt = CG_R;
        txStateNxt = TX_IDLE;
      end
    endcase
  end

  assign txNrzi = nrziEnc(txGroupNxt, txLevel_r);

  always_ff @(posedge core_clk)
  begin
    if (rst || !speed100)
    begin
      txState_r <= TX_IDLE;
    end
    else if (txEvent)
    begin
      txState_r <= txStateNxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lineTransmitPair_r <= CG_IDLE;
      txLevel_r <= 1'b0;
      lineTransmitOff_r <= 1'b0;
    end
    else
    begin
      lineTransmitOff_r <= testLoop;
      if (txEvent && speed100)
      begin
        // one group per nibble clock
        lineTransmitPair_r <= fiberActive ? txNrzi[4:0] : txGroupNxt;
        txLevel_r <= fiberActive ? txNrzi[5] : txLevel_r;
      end
    end
  end

  assign lineTransmitPair = lineTransmitPair_r;
  assign lineTransmitOff = lineTransmitOff_r;
  assign txActive = speed100 ? (txState_r != TX_IDLE) : txEnS_r[1];

  // ***************************************************
  // receive source and decoder
  // ***************************************************
  mpl_rx_state_t rxState_r, rxStateNxt;
  logic rxLevel_r, rxEvent, bad;
  logic [5:0] rxNrzi;
  logic [4:0] g, dec;
  logic rxDv_r, rxEr_r, rxDvNxt, rxErNxt;
  logic [3:0] rxd_r, rxdNxt;

  assign rxNrzi = nrziDec(lrg2_r, rxLevel_r);
  assign rxEvent = loopSel ? txEvent : lineEvent;

  always_comb
  begin
    if (loopSel)
    begin
      g = speed100 ? txGroupNxt : {txEnS_r[1], txd2_r};
    end
    else if (fiberActive)
    begin
      // lost signal reads as idle, so an open frame ends with a receive error
      g = sdS_r[1] ? rxNrzi[4:0] : CG_IDLE;
    end
    else
    begin
      g = lrg2_r;
    end
  end

  assign dec = decode(g);

  always_comb
  begin
    rxStateNxt = RX_IDLE;
    rxDvNxt = 1'b0;
    rxErNxt = 1'b0;
    rxdNxt = 4'h0;
    bad = 1'b0;
    unique case (rxState_r)
      RX_IDLE:
        if (g == CG_J)
        begin
          rxDvNxt = 1'b1;
          rxdNxt = NIB_PREAMBLE;
          rxStateNxt = RX_GOTJ;
        end
      RX_GOTJ:
        if (g == CG_K)
        begin
          rxDvNxt = 1'b1;
          rxdNxt = NIB_PREAMBLE;
          rxStateNxt = RX_FRAME;
        end
        else
        begin
          rxErNxt = 1'b1;
          rxdNxt = NIB_BAD;
          bad = 1'b1;
        end
      RX_FRAME:
        if (dec[4])
        begin
          rxDvNxt = 1'b1;
          rxdNxt = dec[3:0];
          rxStateNxt = RX_FRAME;
        end
        else if (g == CG_T)
        begin
          rxStateNxt = RX_GOTT;
        end
        else if (g == CG_IDLE)
        begin
          rxErNxt = 1'b1;
          bad = 1'b1;
        end
        else
        begin
          rxDvNxt = 1'b1;
          rxErNxt = 1'b1;
          rxdNxt = NIB_BAD;
          rxStateNxt = RX_FRAME;
          bad = 1'b1;
        end
      RX_GOTT:
        if (g != CG_R)
        begin
          rxErNxt = 1'b1;
          bad = 1'b1;
        end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || !speed100)
    begin
      rxState_r <= RX_IDLE;
    end
    else if (rxEvent)
    begin
      rxState_r <= rxStateNxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rxLevel_r <= 1'b0;
    end
    else if (lineEvent && fiberActive)
    begin
      rxLevel_r <= rxNrzi[5];
    end
  end

  // holds the loop for the event that sees transmit enable low, else the
  // last looped nibble would stand as valid and carrier would stick
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      opTail_r <= 1'b0;
    end
    else if (rxEvent)
    begin
      opTail_r <= opLoopOk & txEnS_r[1];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rxDv_r <= 1'b0;
      rxEr_r <= 1'b0;
      rxd_r <= 4'h0;
    end
    else if (rxEvent)
    begin
      // at 10 Mbps bit 4 of the group marks a valid nibble
      rxDv_r <= speed100 ? rxDvNxt : g[4];
      rxEr_r <= speed100 ? rxErNxt : 1'b0;
      rxd_r <= speed100 ? rxdNxt : g[3:0];
    end
  end

  assign rxDv = rxDv_r;
  assign rxEr = rxEr_r;
  assign rxd = rxd_r;
  assign rxActive = speed100 ? (rxState_r != RX_IDLE) : rxDv_r;

  // ***************************************************
  // carrier and collision
  // ***************************************************
  // combinational on purpose: no clock edge between cause and output
  assign crs = rxActive | (~fullDup & txActive);
  // looped data is our own, so it never counts as a collision
  assign col = ~fullDup & txActive & rxActive & ~loopSel;

  // ***************************************************
  // register slave
  // ***************************************************
  logic ack_r;
  logic [31:0] readdata_r;
  logic [ERRCNT_W-1:0] errCnt_r;
  logic wrTake, rdLoad, cntClr;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wrTake = avs_write & ack_r;
  assign rdLoad = avs_read & ~ack_r;
  assign cntClr = wrTake && avs_address == REG_ERRCNT;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_RESET;
    end
    else if (wrTake && avs_address == REG_CTRL && avs_byteenable[0])
    begin
      ctrl_r <= avs_writedata[CTRL_W-1:0];
    end
  end

  // a new error in the clearing cycle still counts
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      errCnt_r <= '0;
    end
    else if (rxEvent && speed100 && bad)
    begin
      errCnt_r <= cntClr ? ERRCNT_W'(1) :
        (&errCnt_r ? errCnt_r : errCnt_r + ERRCNT_W'(1));
    end
    else if (cntClr)
    begin
      errCnt_r <= '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      readdata_r <= 32'h0000_0000;
    end
    else if (rdLoad)
    begin
      readdata_r <= 32'h0000_0000;
      unique case (avs_address)
        REG_CTRL: readdata_r[CTRL_W-1:0] <= ctrl_r;
        REG_STATUS:
        begin
          readdata_r[ST_CRS] <= crs;
          readdata_r[ST_COL] <= col;
          readdata_r[ST_TXACT] <= txActive;
          readdata_r[ST_RXACT] <= rxActive;
          readdata_r[ST_TESTLB] <= testLoop;
          readdata_r[ST_OPLB] <= loopSel & ~testLoop;
          readdata_r[ST_FIBER] <= fiberActive;
        end
        REG_ERRCNT: readdata_r[ERRCNT_W-1:0] <= errCnt_r;
        default: readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = readdata_r;

endmodule : mpl_pcs

// ===== verif/mpl_pcs_properties.sv
// port checker for the coding sublayer, bound to its top module
`timescale 1ns/10ps
module mpl_pcs_props
  import mpl_pcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic txClk,
  input wire logic rxClk,
  input wire logic rxDv,
  input wire logic rxEr,
  input wire logic [3:0] rxd,
  input wire logic crs,
  input wire logic col,
  input wire logic [4:0] lineTransmitPair,
  input wire logic lineTransmitOff
);
  logic [CTRL_W-1:0] ctrl_r;
  logic spd;
  logic plain;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ***************************************************
  // control mirror
  // ***************************************************
  // followed from completed writes, so mode guards need no extra port
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RESET;
    else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL &&
             avs_byteenable[0])
      ctrl_r <= avs_writedata[CTRL_W-1:0];
  end
  assign spd = ctrl_r[CTL_SPEED100];
  assign plain = spd && !ctrl_r[CTL_FIBER];

  // ***************************************************
  // properties
  // ***************************************************
  a_col_with_crs: assert property (col |-> crs)
    else $error("collision without carrier");
  a_fdx_no_col: assert property (ctrl_r[CTL_FULLDUP] |-> !col)
    else $error("collision in full duplex");
  a_clk_pair_same: assert property (rxClk == txClk)
    else $error("interface clocks differ");
  a_clk_fast_period: assert property (
    ($rose(txClk) && spd) ##1 spd [*4] |-> $rose(txClk))
    else $error("fast clock period not four cycles");
  a_line_group_hold: assert property (
    !$rose(txClk) && !lineTransmitOff |-> $stable(lineTransmitPair))
    else $error("line group changed between clock rises");
  a_start_pair_order: assert property (
    $rose(txClk) && plain && lineTransmitPair == CG_J
    |-> ##4 lineTransmitPair == CG_K)
    else $error("start group not followed by its partner");
  a_end_pair_order: assert property (
    $rose(txClk) && plain && lineTransmitPair == CG_T
    |-> ##4 lineTransmitPair == CG_R ##4 lineTransmitPair == CG_IDLE)
    else $error("end group pair or idle missing");
  a_bad_nibble: assert property (rxEr && rxDv |-> rxd == NIB_BAD)
    else $error("receive error without the error nibble");
  a_line_off_cause: assert property (
    lineTransmitOff |-> ctrl_r[CTL_TESTLOOP] || $past(ctrl_r[CTL_TESTLOOP]))
    else $error("line disabled without test loopback");
  c_start_pair: cover property ($rose(txClk) && lineTransmitPair == CG_J);
  c_rx_error: cover property (rxEr);
  c_collision: cover property (col);
endmodule : mpl_pcs_props

bind mpl_pcs mpl_pcs_props chk (.core_clk, .rst, .avs_address, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .txClk, .rxClk, .rxDv,
  .rxEr, .rxd, .crs, .col, .lineTransmitPair, .lineTransmitOff);

// ===== verif/mpl_mac_model.sv
// behavioural MAC transmit side, paced by the interface transmit clock
`timescale 1ns/10ps
module mpl_mac_model
  import mpl_pcs_pkg::*;
(
  input wire logic txClk,
  output logic txEn,
  output logic txEr,
  output logic [3:0] txd,
  output logic busy
);
  logic [5:0] pend[$];
  logic [5:0] cur;
  int gap = 0;

  initial
  begin
    txEn = 1'b0;
    txEr = 1'b0;
    txd = 4'h0;
    busy = 1'b0;
  end

  task automatic push(input logic er, input logic [3:0] nib, input logic last);
    pend.push_back({last, er, nib});
    busy = 1'b1;
  endtask : push

  // ***************************************************
  // nibble pacing
  // ***************************************************
  // the gap leaves at least one idle group after the end pair
  always @(posedge txClk)
  begin
    if (gap > 0)
      gap = gap - 1;
    if (pend.size() != 0 && gap == 0)
    begin
      cur = pend.pop_front();
      txEn <= 1'b1;
      txEr <= cur[4];
      txd <= cur[3:0];
      if (cur[5])
        gap = 4;
    end
    else
    begin
      txEn <= 1'b0;
      txEr <= 1'b0;
      txd <= ~txd;
    end
    busy <= pend.size() != 0 || gap != 0;
  end
endmodule : mpl_mac_model

// ===== verif/mpl_pcs_bench.sv
// self-checking bench for the coding sublayer with a MAC model
`timescale 1ns/10ps
module mpl_pcs_bench
  import mpl_pcs_pkg::*;
;
  logic core_clk = 0;
  logic rst = 1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic txClk;
  logic rxClk;
  logic txEn;
  logic txEr;
  logic [3:0] txd;
  logic rxDv;
  logic rxEr;
  logic [3:0] rxd;
  logic crs;
  logic col;
  logic lineRxClk = 0;
  logic [4:0] lineRxGroup = 5'h1F;
  logic fiberSignalDetect = 0;
  logic [4:0] lineTransmitPair;
  logic lineTransmitOff;
  logic macBusy;
  logic cap = 0;
  logic colExp = 0;
  logic [3:0] nib;
  logic [31:0] rdata;
  logic [4:0] lineQ[$];
  logic [4:0] expLine[$];
  logic [3:0] rxQ[$];
  logic [3:0] expRx[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
    5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
    5'h1D};
  localparam logic [4:0] BAD [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
    5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};
  localparam logic [31:0] SLOW [3] = '{32'h00, 32'h10, 32'h02};

  mpl_pcs uut (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .txClk, .rxClk, .txEn, .txEr, .txd, .rxDv, .rxEr, .rxd, .crs, .col,
    .lineRxClk, .lineRxGroup, .fiberSignalDetect, .lineTransmitPair,
    .lineTransmitOff);
  mpl_mac_model mac (.txClk, .txEn, .txEr, .txd, .busy(macBusy));

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ***************************************************
  // monitor: line group at each rise, receive nibble one edge later
  // ***************************************************
  always @(posedge txClk)
  begin
    @(negedge core_clk);
    if (cap)
      lineQ.push_back(lineTransmitPair);
    @(negedge core_clk);
    if (cap && rxDv === 1'b1)
      rxQ.push_back(rxd);
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic mac_frame(input int len, input int errAt);
    logic [3:0] v;
    cap = 1;
    expLine = '{CG_J, CG_K};
    expRx.delete();
    lineQ.delete();
    rxQ.delete();
    for (int i = 0; i < len; i++)
    begin
      v = (i < 2) ? 4'h5 : 4'($urandom);
      mac.push(i == errAt, v, i == len - 1);
      expRx.push_back(v);
      if (i >= 2)
        expLine.push_back(i == errAt ? CG_H : ENC[v]);
    end
    expLine.push_back(CG_T);
    expLine.push_back(CG_R);
    expLine.push_back(CG_IDLE);
  endtask : mac_frame

  task automatic mac_wait(input logic loop);
    int n;
    n = 0;
    while (macBusy !== 1'b0 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (8) @(posedge core_clk);
    cap = 0;
    if (!loop)
      expRx.delete();
    check("rx count", expRx.size(), rxQ.size());
    foreach (expRx[i])
      check("rx nibble", expRx[i], rxQ[i]);
  endtask : mac_wait

  task automatic line_send(input logic [4:0] g, input logic dv,
                           input logic er, input logic [3:0] d);
    lineRxGroup <= g;
    lineRxClk <= 1'b1;
    repeat (4) @(posedge core_clk);
    lineRxClk <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("rx valid", dv, rxDv);
    check("rx error", er, rxEr);
    if (dv)
    begin
      check("rx nibble", d, rxd);
      check("collision", colExp, col);
      check("carrier", 1, crs);
    end
    repeat (2) @(posedge core_clk);
  endtask : line_send

  task automatic period(input int exp);
    longint t0;
    @(posedge txClk);
    @(posedge txClk);
    t0 = $time;
    @(posedge txClk);
    check("clock period", exp, 32'($time - t0));
    @(posedge core_clk);
  endtask : period

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    void'($urandom(32'hA79C));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(0, REG_CTRL, 0, 4'hF);
    check("ctrl reset", 32'(CTRL_RESET), rdata);
    bus(1, REG_CTRL, 32'h3E, 4'hE);
    bus(1, 8'h0C, 32'hFFFF, 4'hF);
    bus(0, REG_CTRL, 0, 4'hF);
    check("ctrl masked", 32'(CTRL_RESET), rdata);
    bus(0, 8'h0C, 0, 4'hF);
    check("unmapped", 0, rdata);
    period(40);
    $display("test registers done");
    mac_frame(14, 7);
    mac_wait(0);
    while (lineQ.size() > 0 && lineQ[0] === CG_IDLE)
      void'(lineQ.pop_front());
    check("idle lead", 0, (lineQ.size() == 0) ? 32'h1 : 32'h0);
    foreach (expLine[i])
      check("line group", expLine[i], lineQ[i]);
    $display("test transmit done");
    for (int m = 0; m < 2; m++)
    begin
      bus(1, REG_CTRL, m ? 32'h03 : 32'h01, 4'hF);
      colExp = !m;
      mac_frame(70, -1);
      repeat (16) @(posedge core_clk);
      check("tx carrier", !m, crs);
      line_send(CG_IDLE, 0, 0, 0);
      line_send(CG_J, 1, 0, NIB_PREAMBLE);
      line_send(CG_K, 1, 0, NIB_PREAMBLE);
      foreach (BAD[i])
      begin
        nib = 4'($urandom);
        line_send(ENC[nib], 1, 0, nib);
        line_send(BAD[i], 1, 1, NIB_BAD);
      end
      line_send(CG_T, 0, 0, 0);
      line_send(CG_R, 0, 0, 0);
      line_send(CG_J, 1, 0, NIB_PREAMBLE);
      line_send(CG_K, 1, 0, NIB_PREAMBLE);
      line_send(CG_IDLE, 0, 1, 0);
      // line frames above are not loopback: only the rest must stay empty
      rxQ.delete();
      mac_wait(0);
    end
    bus(0, REG_ERRCNT, 0, 4'hF);
    check("error count", 22, rdata);
    bus(1, REG_ERRCNT, 0, 4'hF);
    bus(0, REG_ERRCNT, 0, 4'hF);
    check("error count clear", 0, rdata);
    $display("test receive done");
    bus(1, REG_CTRL, 32'h0B, 4'hF);
    repeat (2) @(posedge core_clk);
    check("line off", 1, lineTransmitOff);
    mac_frame(12, -1);
    mac_wait(1);
    bus(0, REG_STATUS, 0, 4'hF);
    check("test loop status", 1, rdata[ST_TESTLB]);
    fiberSignalDetect <= 1'b1;
    bus(1, REG_CTRL, 32'h29, 4'hF);
    repeat (4) @(posedge core_clk);
    check("fiber line off", 1, lineTransmitOff);
    mac_frame(12, -1);
    mac_wait(1);
    bus(0, REG_STATUS, 0, 4'hF);
    check("fiber status", 1, rdata[ST_FIBER]);
    fiberSignalDetect <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("fiber no detect", 0, lineTransmitOff);
    $display("test loopback done");
    foreach (SLOW[m])
    begin
      bus(1, REG_CTRL, SLOW[m], 4'hF);
      if (m == 0)
        period(400);
      mac_frame(10, -1);
      repeat (60) @(posedge core_clk);
      check("slow carrier", m != 2, crs);
      mac_wait(m == 0);
    end
    $display("test slow link done");
    complete_run();
  end
endmodule : mpl_pcs_bench
